//--- hdl/cidbt_cfg.svh
// register indices, field positions, reset values and limits for the filter and bit timer
`ifndef CIDBT_CFG_SVH
`define CIDBT_CFG_SVH
`define CIDBT_IDX_ID0 12'h5B0
`define CIDBT_IDX_ID1 12'h5B1
`define CIDBT_IDX_ID2 12'h5B2
`define CIDBT_IDX_ID3 12'h5B3
`define CIDBT_IDX_DLC 12'h5B4
`define CIDBT_IDX_PAT0 12'h5C0
`define CIDBT_IDX_MSK0 12'h5C4
`define CIDBT_IDX_FCTL 12'h5C8
`define CIDBT_IDX_BT0 12'h5C9
`define CIDBT_IDX_BT1 12'h5CA
`define CIDBT_IDX_STAT 12'h5CB
`define CIDBT_IDX_QPB 12'h5CC
`define CIDBT_STAT_RXF 0
`define CIDBT_STAT_HIT_LSB 1
`define CIDBT_IDE_BIT 3
`define CIDBT_SRR_BIT 4
`define CIDBT_RTR_STD_BIT 4
`define CIDBT_RTR_EXT_BIT 0
`define CIDBT_BT0_RST 8'h00
`define CIDBT_BT1_RST 8'h13
`define CIDBT_SEG1_MIN 5'h04
`define CIDBT_SEG1_MAX 5'h10
`define CIDBT_SEG2_MIN 4'h2
`define CIDBT_SEG2_MAX 4'h8
`define CIDBT_DLC_MAX 4'h8
`endif

//--- hdl/cidbt_pkg.sv
// types shared by the filter and bit timer
package cidbt_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } cidbt_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cidbt_apb_rsp_t;
  typedef struct packed {
    logic valid;
    logic [3:0][7:0] id;
    logic [3:0] dlc;
  } cidbt_rx_frame_t;
  typedef struct packed {
    logic ide;
    logic rtr;
    logic srr;
    logic [28:0] id;
    logic [31:0] arb_word;
    logic [3:0] dlc;
    logic [3:0] nbytes;
  } cidbt_tx_hdr_t;
  typedef struct packed {
    logic tq_tick;
    logic bit_start;
    logic sample_point;
    logic sampled_bit;
  } cidbt_timing_t;
  typedef enum logic [1:0] {
    CIDBT_SYNC = 2'b00,
    CIDBT_SEG1 = 2'b01,
    CIDBT_SEG2 = 2'b11
  } cidbt_seg_t;
  typedef enum logic [1:0] {
    CIDBT_F32 = 2'b00,
    CIDBT_F16 = 2'b01,
    CIDBT_F8 = 2'b10,
    CIDBT_FCLOSED = 2'b11
  } cidbt_fmode_t;
endpackage : cidbt_pkg

//--- hdl/cidbt_top.sv
// identifier acceptance filter, bit timing and message buffer header with apb registers
// What this block does
// R1: received standard or extended identifiers are compared with programmed patterns
// R2: identifier bits whose mask bit is set are ignored in the compare
// R3: a hit taken while the flag is clear, or cleared in the same cycle, sets the receive buffer full flag and a two-bit hit index
// R4: when several sections match, the lowest numbered one is reported
// R5: software selects one of four filter modes
// R6: single mode uses one 32-bit bank, extended or standard bits, reports filter 0
// R7: prescaler divides the module clock to make the time quantum
// R8: each bit starts with a sync segment of one time quantum, except after a segment two resync jump, which enters segment one directly
// R9: time segment one is 4 to 16 quanta long
// R10: time segment two is 2 to 8 quanta long
// R11: quanta per bit equal one plus segment one plus segment two
// R12: jump width of 1 to 4 quanta limits each resync adjustment
// R13: standard ids use byte 0 and top bits of byte 1, then rtr, ide
// R14: ids are 11 or 29 bits and the top bit goes first
// R15: the smallest identifier value has the highest priority
// R16: software writes the substitute remote request bit as 1 for extended sends
// R17: received substitute remote request bit is stored as received
// R18: extended flag is captured on receive and selects the sent format
// R19: remote flag is captured on receive and sets the sent rtr bit
// R20: length code holds 0 to 8 data bytes for data frames
// R21: remote frames send the length code but no data bytes
`timescale 1ns/1ps
`include "cidbt_cfg.svh"
module cidbt_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire cidbt_pkg::cidbt_apb_req_t apb_req,
  output cidbt_pkg::cidbt_apb_rsp_t apb_rsp,
  input wire cidbt_pkg::cidbt_rx_frame_t rx_frame,
  input wire logic can_rx_pin,
  input wire logic [28:0] arb_peer_id,
  output cidbt_pkg::cidbt_tx_hdr_t tx_hdr,
  output cidbt_pkg::cidbt_timing_t timing,
  output logic arb_we_win,
  output logic rx_buffer_full_flag,
  output logic [1:0] filter_hit_index
);
  import cidbt_pkg::*;

  // byte compare with mask bits as don't care
  function automatic logic byte_match(input logic [7:0] id, input logic [7:0] pat,
                                      input logic [7:0] msk);
    byte_match = (((id ^ pat) & ~msk) == 8'h00); // R1 R2
  endfunction : byte_match

  // word address decode against a register index
  function automatic logic at_idx(input logic [15:0] addr, input logic [11:0] idx);
    at_idx = (addr[15:14] == 2'b00) && (addr[13:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : at_idx

  logic [7:0] id_reg [4];
  logic [7:0] pat_reg [4];
  logic [7:0] msk_reg [4];
  logic [3:0] dlc_reg;
  logic [1:0] fmode_reg;
  logic [7:0] bt0_reg;
  logic [7:0] bt1_reg;
  logic rxf_reg;
  logic [1:0] hit_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // apb decode
  wire setup_ph = apb_req.psel & ~apb_req.penable;
  wire wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
  wire [15:0] addr = apb_req.paddr;
  wire [7:0] wbyte = apb_req.pwdata[7:0];
  wire [3:0] sel_id;
  wire [3:0] sel_pat;
  wire [3:0] sel_msk;
  wire sel_dlc = at_idx(addr, `CIDBT_IDX_DLC);
  wire sel_fctl = at_idx(addr, `CIDBT_IDX_FCTL);
  wire sel_bt0 = at_idx(addr, `CIDBT_IDX_BT0);
  wire sel_bt1 = at_idx(addr, `CIDBT_IDX_BT1);
  wire sel_stat = at_idx(addr, `CIDBT_IDX_STAT);
  wire sel_qpb = at_idx(addr, `CIDBT_IDX_QPB);
  wire mapped;

  // timing fields, lengths with clamps to the legal ranges
  wire [6:0] presc_len = {1'b0, bt0_reg[5:0]} + 7'h01; // R7
  wire [2:0] sjw_len = {1'b0, bt0_reg[7:6]} + 3'h1; // R12
  wire [4:0] seg1_raw = {1'b0, bt1_reg[3:0]} + 5'h01;
  wire [3:0] seg2_raw = {1'b0, bt1_reg[6:4]} + 4'h1;
  wire [4:0] len1 = (seg1_raw < `CIDBT_SEG1_MIN) ? `CIDBT_SEG1_MIN : seg1_raw; // R9
  wire [3:0] len2 = (seg2_raw < `CIDBT_SEG2_MIN) ? `CIDBT_SEG2_MIN : seg2_raw; // R10
  wire [5:0] qpb = 6'h01 + {1'b0, len1} + {2'b00, len2}; // R11

  // per-byte selects and filter compares
  logic [3:0] bm_single;
  logic [3:0] bm_dual;
  logic [3:0] bm_quad;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_byte
      assign sel_id[gi] = at_idx(addr, `CIDBT_IDX_ID0 + 12'(gi));
      assign sel_pat[gi] = at_idx(addr, `CIDBT_IDX_PAT0 + 12'(gi));
      assign sel_msk[gi] = at_idx(addr, `CIDBT_IDX_MSK0 + 12'(gi));
      assign bm_single[gi] = byte_match(rx_frame.id[gi], pat_reg[gi], msk_reg[gi]);
      assign bm_dual[gi] = byte_match(rx_frame.id[gi % 2], pat_reg[gi], msk_reg[gi]);
      assign bm_quad[gi] = byte_match(rx_frame.id[0], pat_reg[gi], msk_reg[gi]);
    end
  endgenerate
  assign mapped = (|sel_id) | (|sel_pat) | (|sel_msk) | sel_dlc | sel_fctl | sel_bt0 |
                  sel_bt1 | sel_stat | sel_qpb;

  // section hits for the selected mode; standard frames skip bytes 2 and 3
  wire rx_ext = rx_frame.id[1][`CIDBT_IDE_BIT];
  wire [3:0] sec_hit;
  wire [1:0] low_hit;
  assign sec_hit = (fmode_reg == CIDBT_F32) ?
                   {3'b000, bm_single[0] & bm_single[1] &
                    ((bm_single[2] & bm_single[3]) | ~rx_ext)} : // R6
                   (fmode_reg == CIDBT_F16) ? {2'b00, bm_dual[3] & bm_dual[2],
                                              bm_dual[1] & bm_dual[0]} :
                   (fmode_reg == CIDBT_F8) ? bm_quad : 4'h0; // R5
  assign low_hit = sec_hit[0] ? 2'd0 : sec_hit[1] ? 2'd1 : sec_hit[2] ? 2'd2 : 2'd3; // R4
  wire accept = rx_frame.valid & (|sec_hit) & (~rxf_reg | rxf_clr);
  wire rxf_clr = wr_acc & sel_stat & apb_req.pwdata[`CIDBT_STAT_RXF];

  // read mux
  wire [31:0] rd_mux;
  assign rd_mux = sel_id[0] ? {24'h0, id_reg[0]} : sel_id[1] ? {24'h0, id_reg[1]} :
                  sel_id[2] ? {24'h0, id_reg[2]} : sel_id[3] ? {24'h0, id_reg[3]} :
                  sel_pat[0] ? {24'h0, pat_reg[0]} : sel_pat[1] ? {24'h0, pat_reg[1]} :
                  sel_pat[2] ? {24'h0, pat_reg[2]} : sel_pat[3] ? {24'h0, pat_reg[3]} :
                  sel_msk[0] ? {24'h0, msk_reg[0]} : sel_msk[1] ? {24'h0, msk_reg[1]} :
                  sel_msk[2] ? {24'h0, msk_reg[2]} : sel_msk[3] ? {24'h0, msk_reg[3]} :
                  sel_dlc ? {28'h0, dlc_reg} : sel_fctl ? {30'h0, fmode_reg} :
                  sel_bt0 ? {24'h0, bt0_reg} : sel_bt1 ? {24'h0, bt1_reg} :
                  sel_stat ? {29'h0, hit_reg, rxf_reg} : sel_qpb ? {26'h0, qpb} : 32'h0;

  // read data and error captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (setup_ph) begin
      prdata_reg <= apb_req.pwrite ? 32'h0 : rd_mux;
      pslverr_reg <= ~mapped;
    end
  end
  assign apb_rsp = '{prdata: prdata_reg, pready: 1'b1, pslverr: pslverr_reg};

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        pat_reg[i] <= 8'h00;
        msk_reg[i] <= 8'hFF;
      end
      fmode_reg <= 2'b00;
      bt0_reg <= `CIDBT_BT0_RST;
      bt1_reg <= `CIDBT_BT1_RST;
    end else if (wr_acc) begin
      for (int i = 0; i < 4; i++) begin
        if (sel_pat[i]) pat_reg[i] <= wbyte;
        if (sel_msk[i]) msk_reg[i] <= wbyte;
      end
      if (sel_fctl) fmode_reg <= wbyte[1:0];
      if (sel_bt0) bt0_reg <= wbyte;
      if (sel_bt1) bt1_reg <= {1'b0, wbyte[6:0]};
    end
  end

  // message buffer: software writes, accepted frames overwrite as received
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) id_reg[i] <= 8'h00;
      dlc_reg <= 4'h0;
    end else if (accept) begin
      for (int i = 0; i < 4; i++) id_reg[i] <= rx_frame.id[i]; // R17 R18 R19
      dlc_reg <= rx_frame.dlc;
    end else if (wr_acc) begin
      for (int i = 0; i < 4; i++) if (sel_id[i]) id_reg[i] <= wbyte;
      if (sel_dlc) dlc_reg <= wbyte[3:0]; // R20
    end
  end

  // full flag and hit index; a new hit wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxf_reg <= 1'b0;
      hit_reg <= 2'b00;
    end else if (accept) begin
      rxf_reg <= 1'b1; // R3
      hit_reg <= low_hit; // R3 R4
    end else if (rxf_clr) begin
      rxf_reg <= 1'b0;
    end
  end
  assign rx_buffer_full_flag = rxf_reg;
  assign filter_hit_index = hit_reg;

  // transmit header from the buffer, standard or extended layout
  wire tx_ext = id_reg[1][`CIDBT_IDE_BIT]; // R18
  wire [28:0] id_std = {18'h0, id_reg[0], id_reg[1][7:5]}; // R13
  wire [28:0] id_ext = {id_reg[0], id_reg[1][7:5], id_reg[1][2:0], id_reg[2],
                        id_reg[3][7:1]};
  wire tx_rtr = tx_ext ? id_reg[3][`CIDBT_RTR_EXT_BIT] : id_reg[1][`CIDBT_RTR_STD_BIT]; // R19
  wire [28:0] tx_id = tx_ext ? id_ext : id_std;
  wire [3:0] dlc_cnt = (dlc_reg > `CIDBT_DLC_MAX) ? `CIDBT_DLC_MAX : dlc_reg; // R20
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hdr <= '0;
      arb_we_win <= 1'b0;
    end else begin
      tx_hdr.ide <= tx_ext;
      tx_hdr.rtr <= tx_rtr;
      tx_hdr.srr <= id_reg[1][`CIDBT_SRR_BIT];
      tx_hdr.id <= tx_id;
      tx_hdr.arb_word <= tx_ext ? {tx_id, 3'b000} : {id_std[10:0], 21'h0}; // R14
      tx_hdr.dlc <= dlc_reg; // R21
      tx_hdr.nbytes <= tx_rtr ? 4'h0 : dlc_cnt; // R21
      arb_we_win <= (tx_id < arb_peer_id); // R15
    end
  end

  // bus pin synchroniser and falling edge detect
  logic rx_s1;
  logic rx_s2;
  logic rx_s3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
    end else begin
      rx_s1 <= can_rx_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end
  wire fall = rx_s3 & ~rx_s2;

  // prescaler for the time quantum
  logic [6:0] pre_cnt;
  wire tq_tick = (pre_cnt + 7'h01 >= presc_len);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pre_cnt <= 7'h00;
    else pre_cnt <= tq_tick ? 7'h00 : pre_cnt + 7'h01; // R7
  end

  // segment sequencer with resync
  cidbt_seg_t seg_reg;
  cidbt_seg_t seg_next;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [2:0] ext_reg;
  logic edge_pend;
  logic samp_reg;
  wire [4:0] e1 = cnt_reg + 5'h01;
  wire [2:0] ext_new = (e1 > {2'b00, sjw_len}) ? sjw_len : e1[2:0]; // R12
  wire [4:0] end1 = len1 + {2'b00, ext_reg};
  wire [3:0] rem2 = len2 - cnt_reg[3:0];
  wire edge_now = fall | edge_pend;
  wire seg2_jump = edge_now && (rem2 <= {1'b0, sjw_len}); // R12
  wire [3:0] end2 = edge_now ? (len2 - {1'b0, sjw_len}) : len2;
  always_comb begin
    seg_next = seg_reg;
    cnt_next = cnt_reg;
    case (seg_reg)
      CIDBT_SYNC: begin
        seg_next = CIDBT_SEG1; // R8
        cnt_next = 5'h00;
      end
      CIDBT_SEG1: begin
        cnt_next = e1;
        if (e1 >= end1) begin // R9
          seg_next = CIDBT_SEG2;
          cnt_next = 5'h00;
        end
      end
      CIDBT_SEG2: begin
        cnt_next = e1;
        if (seg2_jump) begin
          seg_next = CIDBT_SEG1;
          cnt_next = 5'h00;
        end else if (e1[3:0] >= end2) begin // R10 R11
          seg_next = CIDBT_SYNC;
          cnt_next = 5'h00;
        end
      end
      default: begin
        seg_next = CIDBT_SYNC;
        cnt_next = 5'h00;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_reg <= CIDBT_SYNC;
      cnt_reg <= 5'h00;
    end else if (tq_tick) begin
      seg_reg <= seg_next;
      cnt_reg <= cnt_next;
    end
  end

  // edge bookkeeping and phase lengthening in segment one
  wire samp_now = tq_tick && seg_reg == CIDBT_SEG1 && seg_next == CIDBT_SEG2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_pend <= 1'b0;
      ext_reg <= 3'h0;
      samp_reg <= 1'b1;
    end else begin
      edge_pend <= tq_tick ? 1'b0 : (edge_pend | (fall & (seg_reg != CIDBT_SYNC)));
      if (tq_tick && seg_reg == CIDBT_SYNC) ext_reg <= 3'h0;
      else if (tq_tick && seg_reg == CIDBT_SEG1 && edge_now && ext_reg == 3'h0)
        ext_reg <= ext_new; // R12
      if (samp_now)
        samp_reg <= rx_s2;
    end
  end
  // timing strobes, driven as one packed word
  assign timing = '{tq_tick: tq_tick, // R7
                    bit_start: tq_tick && seg_reg == CIDBT_SYNC, // R8
                    sample_point: samp_now,
                    sampled_bit: samp_reg};

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [6:0] gap_cnt;
  logic gap_ok;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt <= 7'h00;
      gap_ok <= 1'b0;
    end else begin
      gap_cnt <= tq_tick ? 7'h00 : gap_cnt + 7'h01;
      gap_ok <= (wr_acc & sel_bt0) ? 1'b0 : (tq_tick ? 1'b1 : gap_ok);
    end
  end
  sequence s_hit_taken;
    rx_frame.valid && (|sec_hit) && (!rxf_reg || rxf_clr);
  endsequence
  sequence s_flag_shown(logic [1:0] h);
    rxf_reg && hit_reg == h;
  endsequence
  a_presc_period: assert property (tq_tick && gap_ok && !(wr_acc & sel_bt0)
    |-> gap_cnt + 7'h01 == presc_len) else $error("quantum period wrong"); // R7
  a_sync_one_tq: assert property (tq_tick && seg_reg == CIDBT_SYNC
    |=> seg_reg == CIDBT_SEG1 && cnt_reg == 5'h00) else $error("sync not one quantum"); // R8
  a_seg1_range: assert property (len1 >= `CIDBT_SEG1_MIN && len1 <= `CIDBT_SEG1_MAX)
    else $error("segment one out of range"); // R9
  a_seg2_range: assert property (len2 >= `CIDBT_SEG2_MIN && len2 <= `CIDBT_SEG2_MAX)
    else $error("segment two out of range"); // R10
  a_qpb_sum: assert property (qpb == 6'h01 + len1 + len2 && qpb >= 6'h07)
    else $error("quanta per bit wrong"); // R11
  a_sjw_limit: assert property (ext_reg <= sjw_len && sjw_len <= 3'h4)
    else $error("jump exceeds width"); // R12
  a_hit_report: assert property (s_hit_taken |=> s_flag_shown($past(low_hit)))
    else $error("hit not reported"); // R3
  a_lowest_hit: assert property (|sec_hit |-> sec_hit[low_hit] &&
    (sec_hit & ((4'h1 << low_hit) - 4'h1)) == 4'h0) else $error("hit not lowest"); // R4
  a_single_f0: assert property (fmode_reg == CIDBT_F32 |-> sec_hit[3:1] == 3'b000)
    else $error("single mode hit not filter 0"); // R6
  a_remote_nodata: assert property (tx_hdr.rtr |-> tx_hdr.nbytes == 4'h0)
    else $error("remote frame with data"); // R21
  a_dlc_bytes: assert property (!tx_hdr.rtr |-> tx_hdr.nbytes <= `CIDBT_DLC_MAX)
    else $error("data count above eight"); // R20
  a_clr_hold: assert property (rxf_reg && !accept && !rxf_clr |=> rxf_reg)
    else $error("full flag lost"); // R3
  a_set_wins: assert property (accept && rxf_clr |=> rxf_reg) // R3
    else $error("clear beat a new hit");
  a_sample_take: assert property (timing.sample_point |=> samp_reg == $past(rx_s2)) // R9
    else $error("bit not sampled at sample point");
  a_code_kept: assert property (tx_hdr.dlc == $past(dlc_reg)) // R21
    else $error("length code not as programmed");
endmodule : cidbt_top

//--- sim/cidbt_peer.sv
// far-side can node model: frames, bus level and a rival identifier
`timescale 1ns/1ps
module cidbt_peer (
  output cidbt_pkg::cidbt_rx_frame_t rx_frame,
  output logic can_rx_pin,
  output logic [28:0] arb_peer_id,
  input wire logic pclk
);
  import cidbt_pkg::*;
  // idle bus is recessive, no rival wins by default
  initial begin
    rx_frame = '0;
    can_rx_pin = 1'b1;
    arb_peer_id = 29'h1FFFFFFF;
  end
  // extended layout, substitute bit sent recessive
  function automatic logic [31:0] ext_bytes(input logic [28:0] id, input logic rtr);
    return {id[6:0], rtr, id[14:7], id[20:18], 1'b1, 1'b1, id[17:15], id[28:21]};
  endfunction : ext_bytes
  // standard layout, extended flag clear
  function automatic logic [31:0] std_bytes(input logic [10:0] id, input logic rtr);
    return {16'h0000, id[2:0], rtr, 1'b0, 3'b000, id[10:3]};
  endfunction : std_bytes
  // one-cycle delivery, then stale bytes scrambled
  task automatic send(input logic [31:0] bytes, input logic [3:0] dlc);
    @(posedge pclk);
    rx_frame <= {1'b1, bytes, dlc};
    @(posedge pclk);
    rx_frame <= {1'b0, ~bytes, ~dlc};
  endtask : send
  task automatic level(input logic v);
    @(posedge pclk);
    can_rx_pin <= v;
  endtask : level
  task automatic rival(input logic [28:0] v);
    @(posedge pclk);
    arb_peer_id <= v;
  endtask : rival
endmodule : cidbt_peer

//--- sim/tb_can_id_filter_bit_timing.sv
// self-checking bench for the filter, bit timer and buffer header
`timescale 1ns/1ps
`include "cidbt_cfg.svh"
`define CHECK_EQ(nm, exp, got) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb_can_id_filter_bit_timing;
  import cidbt_pkg::*;
  logic pclk, presetn, can_rx_pin, arb_we_win, rx_buffer_full_flag, err;
  cidbt_apb_req_t apb_req;
  cidbt_apb_rsp_t apb_rsp;
  cidbt_rx_frame_t rx_frame;
  cidbt_tx_hdr_t tx_hdr;
  cidbt_timing_t timing;
  logic [28:0] arb_peer_id;
  logic [1:0] filter_hit_index;
  logic [31:0] rd;
  int bad_count = 0;
  int compares = 0;
  cidbt_top dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .rx_frame(rx_frame), .can_rx_pin(can_rx_pin), .arb_peer_id(arb_peer_id), .tx_hdr(tx_hdr),
    .timing(timing), .arb_we_win(arb_we_win), .rx_buffer_full_flag(rx_buffer_full_flag),
    .filter_hit_index(filter_hit_index));
  cidbt_peer peer_u (.rx_frame(rx_frame), .can_rx_pin(can_rx_pin),
    .arb_peer_id(arb_peer_id), .pclk(pclk));
  // 200 mhz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic end_of_test();
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  // apb transfer, held until pready seen at an access edge
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= {1'b1, 1'b0, w, {2'b00, idx, 2'b00}, {24'h000000, d}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    @(posedge pclk);
    while (apb_rsp.pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) bad_count++;
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rdchk(input logic [11:0] idx, input logic [7:0] exp, input string nm);
    apb(1'b0, idx, 8'h00);
    `CHECK_EQ(nm, {24'h000000, exp}, rd)
  endtask : rdchk
  task automatic idle(input int n);
    repeat (n) @(negedge pclk);
  endtask : idle
  // cycles between two pulses of a tick or of a bit start
  task automatic gap(input logic sel, output int n);
    n = 0;
    do begin @(negedge pclk); n++; end
    while ((sel ? timing.bit_start : timing.tq_tick) !== 1'b1 && n < 500);
  endtask : gap
  task automatic t_reset();
    rdchk(`CIDBT_IDX_BT0, `CIDBT_BT0_RST, "bt0 reset");
    rdchk(`CIDBT_IDX_BT1, `CIDBT_BT1_RST, "bt1 reset");
    rdchk(`CIDBT_IDX_QPB, 8'h07, "quanta per bit");
    rdchk(`CIDBT_IDX_MSK0, 8'hFF, "mask reset");
    rdchk(`CIDBT_IDX_STAT, 8'h00, "status reset");
    apb(1'b0, 12'h001, 8'h00);
    `CHECK_EQ("unmapped error", 1'b1, err)
    `CHECK_EQ("unmapped data", 32'h0, rd)
  endtask : t_reset
  // single bank, masked bit, refusal while full, arbitration
  task automatic t_single();
    logic [31:0] bp, bf;
    bp = peer_u.ext_bytes(29'h0ABCDE5, 1'b0);
    bf = peer_u.ext_bytes(29'h0AACDE5, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(`CIDBT_IDX_PAT0 + 12'(i), bp[8*i +: 8]);
      wr(`CIDBT_IDX_MSK0 + 12'(i), 8'h00);
    end
    wr(`CIDBT_IDX_FCTL, 8'h00);
    peer_u.send(bf, 4'h3);
    idle(2);
    `CHECK_EQ("miss flag", 1'b0, rx_buffer_full_flag)
    wr(`CIDBT_IDX_MSK0 + 12'h001, 8'h02);
    peer_u.send(bf, 4'h3);
    idle(2);
    `CHECK_EQ("full flag", 1'b1, rx_buffer_full_flag)
    `CHECK_EQ("hit index", 2'd0, filter_hit_index)
    `CHECK_EQ("ext id", 29'h0AACDE5, tx_hdr.id)
    `CHECK_EQ("ext flags", 3'b110, {tx_hdr.ide, tx_hdr.srr, tx_hdr.rtr})
    `CHECK_EQ("ext arb", {29'h0AACDE5, 3'b000}, tx_hdr.arb_word)
    rdchk(`CIDBT_IDX_ID1, bf[15:8], "id byte 1");
    peer_u.send(bp, 4'h1);
    idle(2);
    `CHECK_EQ("kept id", 29'h0AACDE5, tx_hdr.id)
    rdchk(`CIDBT_IDX_STAT, 8'h01, "status full");
    peer_u.rival(29'h0AACDE6);
    idle(2);
    `CHECK_EQ("win", 1'b1, arb_we_win)
    peer_u.rival(29'h0AACDE5);
    idle(2);
    `CHECK_EQ("tie", 1'b0, arb_we_win)
    fork
      wr(`CIDBT_IDX_STAT, 8'h01);
      begin
        @(posedge pclk);
        peer_u.send(bp, 4'h1);
      end
    join
    idle(2);
    `CHECK_EQ("set over clear", 1'b1, rx_buffer_full_flag)
    `CHECK_EQ("late id", 29'h0ABCDE5, tx_hdr.id)
    wr(`CIDBT_IDX_STAT, 8'h01);
    idle(1);
    `CHECK_EQ("cleared", 1'b0, rx_buffer_full_flag)
  endtask : t_single
  // byte, closed and dual filter modes, with a double hit in the byte mode
  task automatic t_modes();
    logic [1:0] md[4] = '{2'd2, 2'd3, 2'd1, 2'd1};
    logic [15:0] fb[4] = '{16'h0055, 16'h0055, 16'h7755, 16'h5511};
    logic ef[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic [1:0] eh[4] = '{2'd1, 2'd0, 2'd1, 2'd0};
    logic [7:0] pv[4] = '{8'h11, 8'h55, 8'h55, 8'h77};
    for (int i = 0; i < 4; i++) begin
      wr(`CIDBT_IDX_PAT0 + 12'(i), pv[i]);
      wr(`CIDBT_IDX_MSK0 + 12'(i), 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      wr(`CIDBT_IDX_FCTL, {6'h00, md[i]});
      peer_u.send({16'h0000, fb[i]}, 4'h2);
      idle(2);
      `CHECK_EQ("mode flag", ef[i], rx_buffer_full_flag)
      if (ef[i]) `CHECK_EQ("mode hit", eh[i], filter_hit_index)
      wr(`CIDBT_IDX_STAT, 8'h01);
    end
  endtask : t_modes
  // standard layout, remote and data frames
  task automatic t_std();
    wr(`CIDBT_IDX_FCTL, 8'h00);
    for (int i = 0; i < 4; i++) wr(`CIDBT_IDX_MSK0 + 12'(i), 8'hFF);
    peer_u.send(peer_u.std_bytes(11'h5A3, 1'b1), 4'h5);
    idle(2);
    `CHECK_EQ("std id", 29'h00005A3, tx_hdr.id)
    `CHECK_EQ("std arb", {11'h5A3, 21'h0}, tx_hdr.arb_word)
    `CHECK_EQ("std ide rtr", 2'b01, {tx_hdr.ide, tx_hdr.rtr})
    `CHECK_EQ("remote count", 8'h50, {tx_hdr.dlc, tx_hdr.nbytes})
    rdchk(`CIDBT_IDX_ID0, 8'hB4, "std byte 0");
    rdchk(`CIDBT_IDX_ID1, 8'h70, "std byte 1");
    wr(`CIDBT_IDX_STAT, 8'h01);
    peer_u.send(peer_u.std_bytes(11'h001, 1'b0), 4'h8);
    idle(2);
    `CHECK_EQ("data rtr", 1'b0, tx_hdr.rtr)
    `CHECK_EQ("data count", 8'h88, {tx_hdr.dlc, tx_hdr.nbytes})
    wr(`CIDBT_IDX_STAT, 8'h01);
  endtask : t_std
  // prescale and segment boundaries, then quanta per bit
  task automatic t_timing();
    logic [7:0] b0[3] = '{8'h02, 8'h00, 8'h01};
    logic [7:0] b1[3] = '{8'h24, 8'h7F, 8'h00};
    int pr[3] = '{3, 1, 2};
    int qb[3] = '{9, 25, 7};
    int n;
    for (int i = 0; i < 3; i++) begin
      wr(`CIDBT_IDX_BT0, b0[i]);
      wr(`CIDBT_IDX_BT1, b1[i]);
      rdchk(`CIDBT_IDX_QPB, 8'(qb[i]), "qpb");
      gap(1'b0, n);
      gap(1'b0, n);
      `CHECK_EQ("tick gap", pr[i], n)
      gap(1'b1, n);
      gap(1'b1, n);
      `CHECK_EQ("bit gap", pr[i] * qb[i], n)
    end
  endtask : t_timing
  // falling edge in segment one stretches the bit by the jump width
  task automatic t_resync();
    int n;
    wr(`CIDBT_IDX_BT0, 8'h00);
    wr(`CIDBT_IDX_BT1, 8'h13);
    gap(1'b1, n);
    gap(1'b1, n);
    peer_u.level(1'b0);
    gap(1'b1, n);
    `CHECK_EQ("resync bit", 7 + 1, n)
    `CHECK_EQ("sampled low", 1'b0, timing.sampled_bit)
    peer_u.level(1'b1);
    gap(1'b1, n);
    `CHECK_EQ("plain bit", 7, n)
    `CHECK_EQ("sampled high", 1'b1, timing.sampled_bit)
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (timing.sample_point !== 1'b1 && n < 50);
    `CHECK_EQ("sample point", 4, n)
  endtask : t_resync
  // watchdog
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    presetn = 1'b0;
    apb_req = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_single();
    t_modes();
    t_std();
    t_timing();
    t_resync();
    end_of_test();
  end
endmodule : tb_can_id_filter_bit_timing
